// [common/tsr_pkg.sv]
// Constants, encodings and state type for the tag RAM scan test port
`default_nettype none

package tsr_pkg;

    // Register lengths
    localparam int IR_LEN  = 3;
    localparam int ID_LEN  = 32;
    localparam int BSR_LEN = 51;

    // Instruction encodings
    localparam logic [2:0] INS_FLOAT_EXT = 3'h0;
    localparam logic [2:0] INS_IDCODE    = 3'h1;
    localparam logic [2:0] INS_FLOAT_SMP = 3'h2;
    localparam logic [2:0] INS_RSVD_3    = 3'h3;
    localparam logic [2:0] INS_SAMPLE    = 3'h4;
    localparam logic [2:0] INS_RSVD_5    = 3'h5;
    localparam logic [2:0] INS_RSVD_6    = 3'h6;
    localparam logic [2:0] INS_BYPASS    = 3'h7;

    // Value forced into the instruction shift stage at capture
    localparam logic [2:0] IR_CAPTURE    = 3'h1;

    // Identification word fields
    localparam int         ID_REV_MSB    = 31;
    localparam int         ID_REV_LSB    = 28;
    localparam logic [4:0] ID_DEPTH      = 5'h07;
    localparam logic [4:0] ID_WIDTH      = 5'h03;
    localparam logic [5:0] ID_RESERVED   = 6'h00;
    localparam logic [0:0] ID_PRESENT    = 1'h1;

    // Reset values of the data registers
    localparam logic [0:0] BYP_RESET     = 1'h0;

    // Port controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } tsr_state_t;

endpackage

`default_nettype wire

// [hw/tsr_shreg.sv]
// Capture and shift register used for every scan register of the port
`default_nettype none

module tsr_shreg #(
    parameter int         W     = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         tck_i,
    input  wire logic         rst_i,
    // Control
    input  wire logic         capture_i,
    input  wire logic         shift_i,
    // Data
    input  wire logic         tdi_i,
    input  wire logic [W-1:0] cap_val_i,
    output logic      [W-1:0] q_o
);

    // Next value: capture, shift towards the low end, or hold
    logic [W-1:0] next_q;

    generate
        if (W == 1) begin : g_one
            assign next_q = capture_i ? cap_val_i : (shift_i ? tdi_i : q_o);
        end else begin : g_many
            // New bit enters at the top, bit 0 leaves first
            assign next_q = capture_i ? cap_val_i : (shift_i ? {tdi_i, q_o[W-1:1]} : q_o);
        end
    endgenerate

    // Register
    always_ff @(posedge tck_i) begin
        if (rst_i) begin
            q_o <= RST;
        end else begin
            q_o <= next_q;
        end
    end

endmodule // tsr_shreg

`default_nettype wire

// [hw/tsr_tap.sv]
// Scan test port of the tag RAM: controller, instruction and data registers
//
// Function
// RL1 - Three-bit instruction register, loaded serially when selected
// RL2 - Reset or test-logic-reset selects the identification instruction
// RL3 - Capture-IR loads 01 into the low bits
// RL4 - Shift-IR moves instruction in, old contents out
// RL5 - New instruction acts only at Update-IR
// RL6 - Bypass bit cleared low under bypass
// RL7 - Bypass instruction routes TDI to TDO through bypass
// RL8 - Boundary register covers 51 pin cells
// RL9 - Sample instructions capture pins, then shift them
// RL10 - TDI feeds the top bit, bottom drives TDO
// RL11 - Identification instruction captures and shifts fixed word
// RL12 - Identification bit 0 leaves first
// RL13 - All-zero instruction samples and floats outputs
// RL14 - Float-and-sample floats outputs and shifts boundary
// RL15 - Sample snapshot never disturbs normal operation
// RL16 - Update-DR under sample has no effect
// RL17 - Port only observes, never drives device pins
// RL18 - Controller must not load reserved codes; the code loads them into instr and decodes them as bypass
// RL19 - Instruction encodings as given in the package
// RL20 - Five TMS-high edges reset the test logic
// RL21 - Inputs on rising edge, TDO on falling edge
// RL22 - Identification bit 0 always reads one
// RL23 - Standard sixteen-state controller steered by TMS
// RL24 - Unselected registers hold, TDO floats outside shifting
`default_nettype none

module tsr_tap
    import tsr_pkg::*;
#(
    parameter logic [3:0]  ID_REVISION = 4'h0,   // Arbitrary value
    parameter logic [10:0] ID_VENDOR   = 11'h2A5 // Arbitrary value
) (
    // System clock domain
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    output logic                           hiz_o,
    // Scan port, clocked by the test clock
    input  wire logic                      tck_i,
    input  wire logic                      tms_i,
    input  wire logic                      tdi_i,
    output logic                           tdo_o,
    output logic                           tdo_oe_o,
    // Observed device pins
    input  wire logic [tsr_pkg::BSR_LEN-1:0] pins_i
);

    import tsr_pkg::*;

    // Fixed identification word, bit 0 marks the register present
    localparam logic [ID_LEN-1:0] ID_CODE =
        {ID_REVISION, ID_DEPTH, ID_WIDTH, ID_RESERVED, ID_VENDOR, ID_PRESENT}; // see RL22

    // Power-up reset brought into the test clock domain
    logic rst_meta;
    logic tap_rst;

    always_ff @(posedge tck_i) begin
        rst_meta <= rst_i;
        tap_rst  <= rst_meta;
    end

    // Pins come from another domain, so two stages before capture
    logic [BSR_LEN-1:0] pins_meta;
    logic [BSR_LEN-1:0] pins_s;

    always_ff @(posedge tck_i) begin
        pins_meta <= pins_i;
        pins_s    <= pins_meta;
    end

    // Port controller state, TMS sampled on rising edges
    tsr_state_t state;
    tsr_state_t next_state;

    always_comb begin
        unique case (state) // see RL23
            ST_RESET:    next_state = tms_i ? ST_RESET    : ST_IDLE;
            ST_IDLE:     next_state = tms_i ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   next_state = tms_i ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   next_state = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms_i ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms_i ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   next_state = tms_i ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   next_state = tms_i ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   next_state = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms_i ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms_i ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   next_state = tms_i ? ST_SEL_DR   : ST_IDLE;
        endcase
    end

    // Five TMS-high edges always land in reset from any state
    always_ff @(posedge tck_i) begin
        if (tap_rst) begin
            state <= ST_RESET;
        end else begin
            state <= next_state; // see RL20
        end
    end

    // State decode
    wire st_reset    = (state == ST_RESET);
    wire st_cap_ir   = (state == ST_CAP_IR);
    wire st_shift_ir = (state == ST_SHIFT_IR);
    wire st_upd_ir   = (state == ST_UPD_IR);
    wire st_cap_dr   = (state == ST_CAP_DR);
    wire st_shift_dr = (state == ST_SHIFT_DR);

    // Instruction shift stage and active instruction
    logic [IR_LEN-1:0] ir_sh;
    logic [IR_LEN-1:0] instr;

    tsr_shreg #(
        .W   (IR_LEN),
        .RST (IR_CAPTURE)
    ) u_ir (
        .tck_i     (tck_i),
        .rst_i     (tap_rst),
        .capture_i (st_cap_ir),   // see RL3
        .shift_i   (st_shift_ir), // see RL1 see RL4
        .tdi_i     (tdi_i),
        .cap_val_i (IR_CAPTURE),
        .q_o       (ir_sh)
    );

    // Active instruction changes only at Update-IR or in reset
    always_ff @(posedge tck_i) begin
        if (tap_rst || st_reset) begin
            instr <= INS_IDCODE; // see RL2
        end else if (st_upd_ir) begin
            instr <= ir_sh; // see RL5
        end
    end

    // Instruction decode; reserved codes fall back to bypass
    wire ins_idcode = (instr == INS_IDCODE);                      // see RL19
    wire ins_float  = (instr == INS_FLOAT_EXT) || (instr == INS_FLOAT_SMP); // see RL13 see RL14
    wire ins_bsr    = ins_float || (instr == INS_SAMPLE);         // see RL15
    wire ins_byp    = !ins_idcode && !ins_bsr;                    // see RL18

    // Data register controls; unselected registers simply hold
    wire cap_id   = st_cap_dr   && ins_idcode;  // see RL11
    wire shf_id   = st_shift_dr && ins_idcode;
    wire cap_bsr  = st_cap_dr   && ins_bsr;     // see RL9
    wire shf_bsr  = st_shift_dr && ins_bsr;
    wire cap_byp  = st_cap_dr   && ins_byp;     // see RL6
    wire shf_byp  = st_shift_dr && ins_byp;     // see RL7

    // Bypass bit, captured low
    logic byp_q;

    tsr_shreg #(
        .W   (1),
        .RST (BYP_RESET)
    ) u_byp (
        .tck_i     (tck_i),
        .rst_i     (tap_rst),
        .capture_i (cap_byp),
        .shift_i   (shf_byp),
        .tdi_i     (tdi_i),
        .cap_val_i (BYP_RESET),
        .q_o       (byp_q)
    );

    // Identification register
    logic [ID_LEN-1:0] id_q;

    tsr_shreg #(
        .W   (ID_LEN),
        .RST (ID_CODE)
    ) u_id (
        .tck_i     (tck_i),
        .rst_i     (tap_rst),
        .capture_i (cap_id),
        .shift_i   (shf_id), // see RL12
        .tdi_i     (tdi_i),
        .cap_val_i (ID_CODE),
        .q_o       (id_q)
    );

    // Boundary register; observe only, no update stage exists
    logic [BSR_LEN-1:0] bsr_q;

    tsr_shreg #(
        .W   (BSR_LEN), // see RL8
        .RST ('0)
    ) u_bsr (
        .tck_i     (tck_i),
        .rst_i     (tap_rst),
        .capture_i (cap_bsr),
        .shift_i   (shf_bsr), // see RL10
        .tdi_i     (tdi_i),
        .cap_val_i (pins_s),
        .q_o       (bsr_q)
    );

    // Serial output selection; Update-DR drives nothing anywhere
    wire dr_bit  = ins_idcode ? id_q[0] : (ins_bsr ? bsr_q[0] : byp_q); // see RL16 see RL17
    wire out_bit = st_shift_ir ? ir_sh[0] : dr_bit;
    wire out_en  = st_shift_ir || st_shift_dr;

    // TDO moves on the falling edge, half a period of margin
    always_ff @(negedge tck_i) begin
        if (tap_rst) begin
            tdo_o    <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else begin
            tdo_o    <= out_bit; // see RL21
            tdo_oe_o <= out_en;  // see RL24
        end
    end

    // Float request registered before it leaves the test domain
    logic float_tck;

    always_ff @(posedge tck_i) begin
        if (tap_rst) begin
            float_tck <= 1'b0;
        end else begin
            float_tck <= ins_float;
        end
    end

    // Two-stage crossing of the float level into the system domain
    logic flt_meta;
    logic flt_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_meta <= 1'b0;
            flt_s    <= 1'b0;
        end else begin
            flt_meta <= float_tck;
            flt_s    <= flt_meta;
        end
    end

    // Output buffer float control for the device
    assign hiz_o = flt_s; // see RL13 see RL14

    // Checks on capture, shift, update, hold and reset behaviour
    a_ir_capture: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL3
        st_cap_ir |=> (ir_sh[1:0] == IR_CAPTURE[1:0]))
        else $error("capture-IR did not load 01");

    a_ir_shift: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL4
        st_shift_ir |=> (ir_sh[2] == $past(tdi_i)) && (ir_sh[1:0] == $past(ir_sh[2:1])))
        else $error("instruction shift path wrong");

    a_ir_update: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL5
        st_upd_ir |=> (instr == $past(ir_sh)))
        else $error("update-IR did not load instruction");

    a_ir_hold: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL5
        (!st_upd_ir && !st_reset) |=> $stable(instr))
        else $error("instruction changed outside update");

    a_reset_idcode: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL2
        st_reset |=> (instr == INS_IDCODE))
        else $error("reset did not select identification");

    a_tms_five: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL20
        tms_i [*5] |=> st_reset)
        else $error("five TMS-high edges did not reset");

    a_bypass_clear: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL6
        cap_byp |=> (byp_q == 1'b0))
        else $error("bypass bit not cleared");

    a_bypass_path: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL7
        shf_byp |=> (byp_q == $past(tdi_i)))
        else $error("bypass did not pass TDI");

    a_id_capture: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL11
        cap_id |=> (id_q == ID_CODE) && (id_q[0] == 1'b1))
        else $error("identification word not captured");

    a_bsr_capture: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL9
        cap_bsr |=> (bsr_q == $past(pins_s)))
        else $error("boundary capture mismatch");

    a_bsr_msb_in: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL10
        shf_bsr |=> (bsr_q[BSR_LEN-1] == $past(tdi_i)))
        else $error("TDI did not enter boundary top bit");

    a_bsr_hold: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL24
        (!cap_bsr && !shf_bsr) |=> $stable(bsr_q))
        else $error("unselected boundary register changed");

    // No preload stage, so Update-DR must leave instruction and float alone
    a_upd_dr_quiet: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL16
        (state == ST_UPD_DR) |=> $stable(instr) && $stable(float_tck))
        else $error("update-DR changed device state");

    a_float_level: assert property (@(posedge tck_i) disable iff (tap_rst) // see RL14
        ins_float |=> float_tck)
        else $error("float request missing");

    a_tdo_float: assert property (@(negedge tck_i) disable iff (tap_rst) // see RL24
        !out_en |=> !tdo_oe_o)
        else $error("TDO driven outside shift states");

    // Main scenarios
    c_id_read:   cover property (@(posedge tck_i) disable iff (tap_rst)
        cap_id ##1 shf_id [*8]);
    c_bypass:    cover property (@(posedge tck_i) disable iff (tap_rst)
        st_upd_ir ##1 (instr == INS_BYPASS) ##[1:20] shf_byp);
    c_bsr_shift: cover property (@(posedge tck_i) disable iff (tap_rst)
        cap_bsr ##1 shf_bsr [*8]);
    c_float:     cover property (@(posedge clk_i) disable iff (rst_i) $rose(hiz_o));

endmodule // tsr_tap

`default_nettype wire

// [tb/tsr_scan_ctl.sv]
// Scan controller model: drives test clock, mode and data, reads TDO
`default_nettype none

module tsr_scan_ctl (
    // Lines toward the device
    output var logic tck_o,
    output var logic tms_o,
    output var logic tdi_o,
    // Serial data back, z while undriven
    input  wire logic tdo_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock parked low between frames, idle lines high as if pulled up
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h1;
    end

    // One 160 ns period; lines move after the fall, TDO taken at the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #80;
        tdo = tdo_i;
        tck_o = 1'h1;
        #80;
        tck_o = 1'h0;
    endtask

    // TMS high for n rises, then parked in idle
    task automatic tap_reset(input int n);
        logic b;
        #13;
        repeat (n) step(1'h1, 1'h1, b);
        step(1'h0, 1'h1, b);
    endtask

    // Capture, shift n bits LSB first, update, idle; offset keeps tck off the clk phase
    task automatic frame(input logic is_ir, input logic [63:0] din, input int n,
                         output logic [63:0] dout);
        logic b;
        #13;
        step(1'h1, 1'h1, b);
        if (is_ir) begin
            step(1'h1, 1'h1, b);
        end
        step(1'h0, 1'h1, b);
        step(1'h0, 1'h1, b);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'h1, 1'h1, b);
        repeat (4) step(1'h0, 1'h1, b);
    endtask

endmodule // tsr_scan_ctl

`default_nettype wire

// [tb/tsr_tap_tb_top.sv]
// Self-checking bench of the tag RAM scan test port
`default_nettype none

module tsr_tap_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tsr_pkg::*;

    localparam logic [3:0]  REV   = 4'h5;   // Arbitrary value
    localparam logic [10:0] VEN   = 11'h3C9; // Arbitrary value
    localparam logic [31:0] IDW   = {REV, ID_DEPTH, ID_WIDTH, ID_RESERVED, VEN, ID_PRESENT};
    localparam int          LIMIT = 10000;  // Run needs about 2000 cycles

    logic               clk_i     = 1'h0;
    logic               rst_i     = 1'h1;
    logic [BSR_LEN-1:0] pins      = 51'h5_A3C9_0F1E_2D4B;
    logic               hiz, tck, tms, tdi, tdo, tdo_oe;
    wire                tdo_w;
    int                 errors    = 0;
    int                 cmp_count = 0;
    int                 cycles    = 0;

    // TDO pin floats whenever the port does not drive it
    assign tdo_w = tdo_oe ? tdo : 1'bz;

    // Device port and its scan controller
    tsr_tap #(.ID_REVISION(REV), .ID_VENDOR(VEN)) i_tsr_tap (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .hiz_o    (hiz),
        .tck_i    (tck),
        .tms_i    (tms),
        .tdi_i    (tdi),
        .tdo_o    (tdo),
        .tdo_oe_o (tdo_oe),
        .pins_i   (pins)
    );
    tsr_scan_ctl i_tsr_scan_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));

    // 25 MHz system clock
    always #20 clk_i = ~clk_i;

    // Hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("MISMATCH %0t timeout", $time);
            conclude();
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // Default instruction reads the ID word, TDI bits trail it out
    task automatic t_reset_id();
        logic [63:0] d;
        chk_flag(tdo_oe, 1'h0, "tdo floats after reset");
        i_tsr_scan_ctl.frame(1'h0, 64'hFF, 40, d);
        chk_vec(d, {24'h0, 8'hFF, IDW}, "id word");
        chk_flag(d[0], 1'h1, "id present bit first");
    endtask

    // Bypass gives a one-bit path that captures low; only the bypass code itself is loaded
    task automatic t_bypass();
        logic [63:0] d;
        logic [7:0]  pat;
        for (int k = 0; k < 2; k++) begin
            pat = k ? 8'h5A : 8'hA5;
            i_tsr_scan_ctl.frame(1'h1, {61'h0, INS_BYPASS}, 3, d);
            chk_vec(d, {61'h0, IR_CAPTURE}, "ir capture pattern");
            i_tsr_scan_ctl.frame(1'h0, {56'h0, pat}, 9, d);
            chk_vec(d, {55'h0, pat, 1'h0}, "bypass path");
        end
    endtask

    // Six-bit IR shift shows length and capture; sample snaps live pins twice
    task automatic t_sample();
        logic [63:0] d;
        i_tsr_scan_ctl.frame(1'h1, {58'h0, INS_SAMPLE, 3'h5}, 6, d);
        chk_vec(d, {58'h0, 3'h5, IR_CAPTURE}, "ir length and capture");
        repeat (2) begin
            i_tsr_scan_ctl.frame(1'h0, 64'h3C, 59, d);
            chk_vec(d, {5'h0, 8'h3C, pins}, "sample capture");
            chk_flag(hiz, 1'h0, "sample keeps outputs");
            @(negedge clk_i);
            pins = ~pins;
        end
    endtask

    // Both float codes drop outputs to high-Z and still capture pins
    task automatic t_float();
        logic [63:0] d;
        logic [2:0]  code;
        for (int k = 0; k < 2; k++) begin
            code = k ? INS_FLOAT_SMP : INS_FLOAT_EXT;
            i_tsr_scan_ctl.frame(1'h1, {61'h0, code}, 3, d);
            chk_flag(hiz, 1'h1, "outputs floated");
            i_tsr_scan_ctl.frame(1'h0, 64'h0, 51, d);
            chk_vec(d, {13'h0, pins}, "float capture");
            i_tsr_scan_ctl.frame(1'h1, {61'h0, INS_IDCODE}, 3, d);
            chk_flag(hiz, 1'h0, "outputs released");
        end
    endtask

    // Five TMS-high rises bring back the ID instruction
    task automatic t_tms_reset();
        logic [63:0] d;
        i_tsr_scan_ctl.frame(1'h1, {61'h0, INS_BYPASS}, 3, d);
        i_tsr_scan_ctl.tap_reset(5);
        #1;
        chk_flag(tdo_oe, 1'h0, "tdo floats in idle");
        i_tsr_scan_ctl.frame(1'h0, 64'h0, 32, d);
        chk_vec(d, {32'h0, IDW}, "id after tms reset");
    endtask

    // Reset spans several test clock rises, since it is synced into that domain
    initial begin
        fork
            i_tsr_scan_ctl.tap_reset(8);
            begin
                repeat (16) @(negedge clk_i);
                rst_i = 1'h0;
            end
        join
        t_reset_id();
        t_bypass();
        t_sample();
        t_float();
        t_tms_reset();
        conclude();
    end

endmodule // tsr_tap_tb_top

`default_nettype wire
